//--- srpc_cmd.v
`timescale 1ns/100ps
`include "srpc_defines.vh"
module srpc_cmd (
  input wire clock_i,
  input wire sys_rst_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire mosi_i,
  input wire wp_n_i,
  input wire op_start_i,
  input wire [1:0] op_kind_i,
  input wire op_done_i,
  input wire [2:0] cmd_class_i,
  input wire [7:0] spr_byte_i,
  output reg [7:0] cmd_opcode_o,
  output reg cmd_go_o,
  output reg cmd_reject_o,
  output reg op_suspend_o,
  output reg op_resume_o,
  output reg [1:0] op_kind_o,
  output wire busy_o,
  output wire buf1_prog_suspended_o,
  output wire buf2_prog_suspended_o,
  output wire erase_suspended_o,
  output wire prot_enabled_o,
  output wire sector_blocked_o
);

  // Two-stage sync on every pin
  reg cs_s1_q;
  reg cs_s2_q;
  reg cs_s3_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg mosi_s1_q;
  reg mosi_s2_q;
  reg wp_s1_q;
  reg wp_s2_q;
  reg [5:0] bits_q;
  reg [31:0] shift_q;
  reg [7:0] opc_q;
  reg run_q;
  reg ps1_q;
  reg ps2_q;
  reg es_q;
  reg sw_prot_q;
  reg [`SRPC_RES_W-1:0] res_cnt_q;
  reg [`SRPC_RES_W-1:0] res_cnt_d;
  reg run_d;
  reg [1:0] kind_d;
  reg ps1_d;
  reg ps2_d;
  reg es_d;
  reg cls_ok;

  wire sck_rise;
  wire cs_rise;
  wire cs_fall;
  wire has_opc;
  wire is_prot_seq;
  wire susp_any;
  wire resuming;
  wire dec_any;
  wire dec_suspend;
  wire dec_resume;
  wire dec_prot;
  wire dec_other;
  wire do_suspend;
  wire do_resume;
  wire prot_en_seq;
  wire prot_dis_seq;

  assign sck_rise = sck_s2_q & ~sck_s3_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign cs_fall = ~cs_s2_q & cs_s3_q;
  // Opcode alone is enough; trailing bytes matter only to the 3Dh protection sequence
  assign has_opc = (bits_q >= `SRPC_BITS_OPC);
  // Exactly four bytes, deselect right after the last bit
  assign is_prot_seq = (bits_q == `SRPC_BITS_SEQ) && (shift_q[31:8] == `SRPC_PROT_SEQ);
  assign susp_any = ps1_q | ps2_q | es_q;
  assign resuming = (res_cnt_q != {`SRPC_RES_W{1'b0}});

  // Kind compare shared by the decoders
  function kind_is;
    input [1:0] kind;
    input [1:0] want;
    begin
      kind_is = (kind == want);
    end
  endfunction

  // Class from the outer opcode decoder for the current opcode
  always @* begin
    cls_ok = 1'b1;
    if (susp_any) begin
      case (cmd_class_i)
        `SRPC_CLS_ALWAYS: begin
          cls_ok = 1'b1;
        end
        `SRPC_CLS_NEVER: begin
          cls_ok = 1'b0;
        end
        `SRPC_CLS_NOT_PS1: begin
          cls_ok = !ps1_q;
        end
        `SRPC_CLS_NOT_PS2: begin
          cls_ok = !ps2_q;
        end
        `SRPC_CLS_ES_ONLY: begin
          cls_ok = !ps1_q && !ps2_q;
        end
        default: begin
          cls_ok = 1'b0;
        end
      endcase
    end
  end

  // Only the opcode byte decodes; trailing bytes matter only to a 3Dh protection sequence
  assign dec_any = cs_rise && has_opc;
  assign dec_suspend = dec_any && (opc_q == `SRPC_OPC_SUSPEND);
  assign dec_resume = dec_any && (opc_q == `SRPC_OPC_RESUME);
  assign dec_prot = dec_any && ((opc_q == `SRPC_OPC_PROT_PFX) || (opc_q == `SRPC_OPC_CHIP_ERASE));
  assign dec_other = dec_any && !dec_suspend && !dec_resume && !dec_prot;
  // Restart still in flight: the engine cannot stop yet
  assign do_suspend = dec_suspend && run_q && !resuming && !kind_is(op_kind_o, `SRPC_OP_IDLE);
  assign do_resume = dec_resume && !run_q && susp_any;
  assign prot_en_seq = is_prot_seq && (shift_q[7:0] == `SRPC_PROT_EN);
  assign prot_dis_seq = is_prot_seq && (shift_q[7:0] == `SRPC_PROT_DIS);

  // Select and write-protect idle high, so no false edge after reset
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      mosi_s1_q <= mosi_i;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      wp_s1_q <= wp_n_i;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Shifter takes at most 33 bits and keeps the last 32 of them
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bits_q <= 6'h00;
      shift_q <= 32'h00000000;
      opc_q <= 8'h00;
    end else if (cs_fall) begin
      bits_q <= 6'h00;
    end else if (!cs_s2_q && sck_rise && (bits_q <= `SRPC_BITS_SEQ)) begin
      bits_q <= bits_q + 6'h01;
      shift_q <= {shift_q[30:0], mosi_s2_q};
      if (bits_q == (`SRPC_BITS_OPC - 6'h01)) begin
        opc_q <= {shift_q[6:0], mosi_s2_q};
      end
    end
  end

  // Pulses last one cycle and carry the decoded opcode
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_go_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      op_suspend_o <= 1'b0;
      op_resume_o <= 1'b0;
      cmd_opcode_o <= 8'h00;
    end else begin
      cmd_go_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      op_suspend_o <= do_suspend;
      op_resume_o <= do_resume;
      if (dec_prot) begin
        if (susp_any) begin
          cmd_reject_o <= 1'b1;
        end else if (!prot_en_seq && !prot_dis_seq) begin
          cmd_go_o <= 1'b1;
        end
      end else if (dec_other) begin
        if (cls_ok) begin
          cmd_go_o <= 1'b1;
        end else begin
          cmd_reject_o <= 1'b1;
        end
      end
      if (dec_any) begin
        cmd_opcode_o <= opc_q;
      end
    end
  end

  // Buffer 1 program first, then buffer 2; erase waits until no program is suspended
  always @* begin
    run_d = run_q;
    kind_d = op_kind_o;
    if (do_suspend) begin
      run_d = 1'b0;
    end else if (do_resume) begin
      run_d = 1'b1;
      if (ps1_q) begin
        kind_d = `SRPC_OP_PROG1;
      end else if (ps2_q) begin
        kind_d = `SRPC_OP_PROG2;
      end else begin
        kind_d = `SRPC_OP_ERASE;
      end
    end else if (op_done_i && run_q) begin
      run_d = 1'b0;
      kind_d = `SRPC_OP_IDLE;
    end else if (op_start_i && !run_q) begin
      run_d = 1'b1;
      kind_d = op_kind_i;
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      op_kind_o <= `SRPC_OP_IDLE;
    end else begin
      run_q <= run_d;
      op_kind_o <= kind_d;
    end
  end

  // Suspend sets one flag; resume clears the one it restarts
  always @* begin
    ps1_d = ps1_q;
    ps2_d = ps2_q;
    es_d = es_q;
    if (do_suspend) begin
      ps1_d = ps1_q | kind_is(op_kind_o, `SRPC_OP_PROG1);
      ps2_d = ps2_q | kind_is(op_kind_o, `SRPC_OP_PROG2);
      es_d = es_q | kind_is(op_kind_o, `SRPC_OP_ERASE);
    end else if (do_resume) begin
      if (ps1_q) begin
        ps1_d = 1'b0;
      end else if (ps2_q) begin
        ps2_d = 1'b0;
      end else begin
        es_d = 1'b0;
      end
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ps1_q <= 1'b0;
      ps2_q <= 1'b0;
      es_q <= 1'b0;
    end else begin
      ps1_q <= ps1_d;
      ps2_q <= ps2_d;
      es_q <= es_d;
    end
  end

  // Volatile: reset leaves software protection off
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sw_prot_q <= 1'b0;
    end else if (dec_prot && !susp_any && prot_en_seq) begin
      sw_prot_q <= 1'b1;
    end else if (dec_prot && !susp_any && prot_dis_seq) begin
      sw_prot_q <= 1'b0;
    end
  end

  // Window in which a new suspend is ignored
  always @* begin
    res_cnt_d = res_cnt_q;
    if (do_resume) begin
      res_cnt_d = `SRPC_RES_CYC;
    end else if (resuming) begin
      res_cnt_d = res_cnt_q - {{(`SRPC_RES_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_cnt_q <= {`SRPC_RES_W{1'b0}};
    end else begin
      res_cnt_q <= res_cnt_d;
    end
  end

  assign busy_o = run_q;
  assign buf1_prog_suspended_o = ps1_q;
  assign buf2_prog_suspended_o = ps2_q;
  assign erase_suspended_o = es_q;
  // Pad pull-up keeps a floating pin high, leaving software in charge
  assign prot_enabled_o = sw_prot_q | ~wp_s2_q;
  assign sector_blocked_o = prot_enabled_o && (spr_byte_i == `SRPC_SPR_PROTECTED);

endmodule // srpc_cmd

//--- srpc_cmd_asserts.sv
`timescale 1ns/100ps
module srpc_cmd_chk (
  input wire clock_i,
  input wire sys_rst_i,
  input wire wp_n_i,
  input wire op_done_i,
  input wire [7:0] spr_byte_i,
  input wire cmd_reject_o,
  input wire op_suspend_o,
  input wire op_resume_o,
  input wire [1:0] op_kind_o,
  input wire busy_o,
  input wire buf1_prog_suspended_o,
  input wire buf2_prog_suspended_o,
  input wire erase_suspended_o,
  input wire prot_enabled_o,
  input wire sector_blocked_o
);
  wire [2:0] flg = {buf1_prog_suspended_o, buf2_prog_suspended_o, erase_suspended_o};
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  susp_sets_flag_a: assert property (op_suspend_o |-> !busy_o && flg != 3'h0) else $error("suspend flag");
  resume_busy_a: assert property (op_resume_o |-> busy_o && op_kind_o != 2'h0) else $error("resume busy");
  resume_clear_a: assert property (op_resume_o && op_kind_o == 2'h1 |-> !flg[2]) else $error("resume flag");
  prog_first_a: assert property (op_resume_o && op_kind_o == 2'h3 |-> flg[2:1] == 2'h0) else $error("order");
  no_resuspend_a: assert property (op_resume_o |=> !op_suspend_o [*8]) else $error("suspend in resume");
  resume_holds_a: assert property (op_resume_o ##1 !op_done_i |-> busy_o) else $error("resume dropped");
  reject_quiet_a: assert property (cmd_reject_o |-> $stable(flg) && $stable(busy_o)) else $error("reject side effect");
  sector_gate_a: assert property (sector_blocked_o == (prot_enabled_o && spr_byte_i == 8'hFF)) else $error("gate");
  wp_prot_a: assert property (!wp_n_i [*3] |-> prot_enabled_o) else $error("pin protection");
endmodule // srpc_cmd_chk
bind srpc_cmd srpc_cmd_chk srpc_cmd_chk_inst (.clock_i, .sys_rst_i, .wp_n_i, .op_done_i, .spr_byte_i, .cmd_reject_o,
  .op_suspend_o, .op_resume_o, .op_kind_o, .busy_o, .buf1_prog_suspended_o, .buf2_prog_suspended_o,
  .erase_suspended_o, .prot_enabled_o, .sector_blocked_o);

//--- srpc_cmd_tb_top.sv
`timescale 1ns/100ps
module srpc_cmd_tb_top;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, wp_n_i = 1'b1, op_start_i = 1'b0, op_done_i = 1'b0;
  logic [1:0] op_kind_i = 2'h0;
  logic [2:0] cmd_class_i = 3'h0;
  logic [7:0] spr_byte_i = 8'h00;
  wire [7:0] opc;
  wire [1:0] kind;
  wire cs_n, sck, mosi, go, rej, sus, res, busy, ps1, ps2, es, prot, blk;
  wire [7:0] flg = {3'h0, prot, ps1, ps2, es, busy};
  int err_count = 0, n_checks = 0, ngo = 0, nrej = 0, nsus = 0, nres = 0;
  srpc_host srpc_host_inst (.cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi));
  srpc_cmd srpc_cmd_inst (.clock_i, .sys_rst_i, .cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi), .wp_n_i, .op_start_i,
    .op_kind_i, .op_done_i, .cmd_class_i, .spr_byte_i, .cmd_opcode_o(opc), .cmd_go_o(go), .cmd_reject_o(rej),
    .op_suspend_o(sus), .op_resume_o(res), .op_kind_o(kind), .busy_o(busy), .buf1_prog_suspended_o(ps1),
    .buf2_prog_suspended_o(ps2), .erase_suspended_o(es), .prot_enabled_o(prot), .sector_blocked_o(blk));
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ngo += (go === 1'b1);
    nrej += (rej === 1'b1);
    nsus += (sus === 1'b1);
    nres += (res === 1'b1);
  end
  task automatic chk(input logic [7:0] exp, got, input string nm);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Pulse bits go, reject, suspend, resume; x in go means either is fine
  task automatic cmd(input logic [31:0] d, input int n, input logic [3:0] exp);
    int g, r, s, m;
    logic [3:0] seen;
    g = ngo; r = nrej; s = nsus; m = nres;
    srpc_host_inst.frame(d, n);
    seen = {ngo != g, nrej != r, nsus != s, nres != m};
    if (exp[3] === 1'bx) seen[3] = 1'bx;
    chk({4'h0, exp}, {4'h0, seen}, "pulses");
  endtask
  task automatic op(input logic [1:0] k, input logic st);
    @(posedge clock_i);
    #1 op_kind_i = k; op_start_i = st; op_done_i = ~st;
    @(posedge clock_i);
    #1 op_start_i = 1'b0; op_done_i = 1'b0;
  endtask
  function automatic logic exp_go(input logic [2:0] c, input logic p1, p2, e);
    case (c)
      3'h0: return 1'b1;
      3'h2: return !p1;
      3'h3: return !p2;
      3'h4: return e && !p1 && !p2;
      default: return 1'b0;
    endcase
  endfunction
  task automatic classes(input logic p1, p2, e);
    logic [7:0] o;
    for (int c = 0; c < 5; c++) begin
      o = 8'h01 + 8'($urandom % 60);
      @(posedge clock_i);
      #1 cmd_class_i = c[2:0]; spr_byte_i = 8'($urandom);
      cmd({24'h0, o}, 8, {exp_go(c[2:0], p1, p2, e), !exp_go(c[2:0], p1, p2, e), 2'h0});
      chk(o, opc, "opcode");
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    complete_run;
  end
  initial begin
    void'($urandom(32'had79e6ee));
    repeat (12) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    repeat (3) @(posedge clock_i);
    chk(8'h00, flg, "after reset");
    op(2'h3, 1'b1);
    cmd(32'hB0, 8, 4'b0010);
    chk(8'h02, flg, "erase suspend");
    classes(1'b0, 1'b0, 1'b1);
    cmd(32'h3D2A7FA9, 32, 4'b0100);
    cmd(32'hC7, 8, 4'b0100);
    chk(8'h02, flg, "after rejects");
    op(2'h1, 1'b1);
    cmd(32'hB0, 8, 4'b0010);
    chk(8'h0A, flg, "both suspended");
    classes(1'b1, 1'b0, 1'b1);
    cmd({16'h0, 8'hD0, 8'($urandom)}, 16, 4'b0001);
    chk(8'h03, flg, "program resumed");
    chk(8'h01, {6'h0, kind}, "kind");
    cmd(32'hB0, 8, 4'b0000);
    op(2'h0, 1'b0);
    cmd(32'hD0, 8, 4'b0001);
    chk(8'h01, flg, "erase resumed");
    chk(8'h03, {6'h0, kind}, "kind");
    op(2'h0, 1'b0);
    cmd(32'hD0, 8, 4'b0000);
    cmd(32'h3D2A7FA9, 32, 4'b0000);
    chk(8'h10, flg, "protect on");
    @(posedge clock_i);
    #1 spr_byte_i = 8'hFF;
    #1 chk(8'h01, {7'h0, blk}, "blocked");
    cmd(32'h3D2A7F9A, 32, 4'b0000);
    chk(8'h00, flg, "protect off");
    chk(8'h00, {7'h0, blk}, "unblocked");
    @(posedge clock_i);
    #1 wp_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1 chk(8'h10, flg, "pin protect");
    complete_run;
  end
endmodule // srpc_cmd_tb_top

//--- srpc_defines.vh
// Function
// - Resume is opcode D0h; extra bytes ignored
// - Resume restarts suspended operation at deselect
// - Resume clears its suspend flag, shows busy
// - Program resumes before erase; reissue resume
// - Suspend ignored while resume still starting
// - 3Dh 2Ah 7Fh A9h enables protection
// - 3Dh 2Ah 7Fh 9Ah disables protection
// - Software protection cleared at power-up
// - Unconnected write-protect pin reads inactive
// - Block program/erase only to selected sectors
// - Status shows protection enabled, either source
// - Suspend rejects protection commands, sector/chip erase
// - Suspend rejects lockdown/security programs, allows reads
// - Suspend rejects all power-down commands
// - Suspend allows config, status, ID reads
// - Hardware and software reset always accepted
// - Buffer transfer rejected only for suspended buffer
// - Buffer compares always accepted during suspend
// - Suspend is opcode B0h, acts at deselect
// - Suspend sets matching flag, reports ready
// - Protection byte FFh marks sector protected
`ifndef SRPC_DEFINES_VH
`define SRPC_DEFINES_VH
`define SRPC_OPC_SUSPEND 8'hB0
`define SRPC_OPC_RESUME 8'hD0
`define SRPC_OPC_PROT_PFX 8'h3D
`define SRPC_OPC_CHIP_ERASE 8'hC7
`define SRPC_PROT_SEQ 24'h3D2A7F
`define SRPC_PROT_EN 8'hA9
`define SRPC_PROT_DIS 8'h9A
`define SRPC_SPR_PROTECTED 8'hFF
`define SRPC_BITS_OPC 6'h08
`define SRPC_BITS_SEQ 6'h20
`define SRPC_OP_IDLE 2'h0
`define SRPC_OP_PROG1 2'h1
`define SRPC_OP_PROG2 2'h2
`define SRPC_OP_ERASE 2'h3
`define SRPC_CLS_ALWAYS 3'h0
`define SRPC_CLS_NEVER 3'h1
`define SRPC_CLS_NOT_PS1 3'h2
`define SRPC_CLS_NOT_PS2 3'h3
`define SRPC_CLS_ES_ONLY 3'h4
// Resume window: 50 us at the 100 ns clock
`define SRPC_RES_CYC 10'h1F4
`define SRPC_RES_W 10
`endif

//--- srpc_host.sv
`timescale 1ns/100ps
module srpc_host (
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Clock parked low outside frames; data flipped once released
  task automatic frame(input logic [31:0] d, input int n);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = d[i];
      #400 sck_o = 1'b1;
      #400 sck_o = 1'b0;
    end
    #400 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #1200;
  endtask
endmodule // srpc_host
